// >>> hdl/gpio_defs.vh
/*
 * register offsets, field positions, reset values and timing counts of the
 * general purpose i/o port. assumes inclusion by bare name.
 */
`ifndef GPIO_DEFS_VH
`define GPIO_DEFS_VH

// ----------------------------------------
// register byte offsets (axi4-lite)
// ----------------------------------------
`define GPIO_OFS_DATA 4'h0
`define GPIO_OFS_DIR 4'h4
`define GPIO_OFS_PULL 4'h8
`define GPIO_OFS_STBY 4'hc

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define GPIO_STBY_HIZ_BIT 0
`define GPIO_STBY_STOP_BIT 1
`define GPIO_STBY_WATCH_BIT 2
`define GPIO_STBY_LATCH_RD_BIT 3
`define GPIO_DIR_RESET 8'h00
`define GPIO_DATA_RESET 8'h00
`define GPIO_PULL_RESET 8'h00
`define GPIO_STBY_RESET 4'h0

// ----------------------------------------
// axi responses
// ----------------------------------------
`define GPIO_RESP_OKAY 2'b00
`define GPIO_RESP_SLVERR 2'b10

// pin synchroniser depth
`define GPIO_SYNC_STAGES 3

`endif

// >>> hdl/gpio_pin_sync.v
/*
 * three-stage pin synchroniser, one per pin via generate.
 * assumes pins are asynchronous to sys_clk; output changes once the second
 * and third stages agree.
 */
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_sync #(
  parameter WIDTH = 8
) (
  input wire sys_clk,
  input wire rst,
  input wire ce,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg val_reg;
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          val_reg <= 1'b0;
        end else if (ce) begin
          s1_reg <= async_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          // only accept a level both later stages agree on
          if (s2_reg == s3_reg) begin
            val_reg <= s3_reg;
          end
        end
      end
      assign sync_out[i] = val_reg;
    end
  endgenerate
endmodule // gpio_pin_sync
`default_nettype wire

// >>> hdl/gpio_port.v
/*
 * general purpose i/o port: data latch, direction and pull-up per pin,
 * standby high-impedance forcing, axi4-lite register slave.
 * assumes one clock, asynchronous active-high reset, pads resolved outside
 * from pin_out / pin_oe / pin_pullup_en.
 */
`timescale 1ns/10ps
`default_nettype none
`include "gpio_defs.vh"
module gpio_port #(
  parameter WIDTH = 8
) (
  input wire sys_clk,
  input wire rst,
  input wire ce,
  // axi4-lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // pins
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_out,
  output reg [WIDTH-1:0] pin_oe,
  output reg [WIDTH-1:0] pin_pullup_en,
  // value seen by peripherals sharing the pins
  output reg [WIDTH-1:0] periph_in
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [WIDTH-1:0] data_latch_reg;
  reg [WIDTH-1:0] direction_reg;
  reg [WIDTH-1:0] pullup_reg;
  reg [3:0] standby_control_reg;
  wire [WIDTH-1:0] pin_sync;
  wire standby_hiz;

  gpio_pin_sync #(
    .WIDTH(WIDTH)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // hiz select with stop or watch
  assign standby_hiz = standby_control_reg[`GPIO_STBY_HIZ_BIT] &
    (standby_control_reg[`GPIO_STBY_STOP_BIT] | standby_control_reg[`GPIO_STBY_WATCH_BIT]);

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  reg aw_held_reg;
  reg w_held_reg;
  reg [3:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire aw_take;
  wire w_take;
  wire wr_go;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  // both halves present and no response pending
  assign wr_go = aw_held_reg & w_held_reg & ~s_axi_bvalid;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GPIO_RESP_OKAY;
      direction_reg <= `GPIO_DIR_RESET;
      data_latch_reg <= `GPIO_DATA_RESET;
      pullup_reg <= `GPIO_PULL_RESET;
      standby_control_reg <= `GPIO_STBY_RESET;
    end else if (ce) begin
      s_axi_awready <= ~aw_held_reg & ~aw_take;
      s_axi_wready <= ~w_held_reg & ~w_take;
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `GPIO_RESP_OKAY;
        // registers are at most one byte wide: only lane 0 matters
        if (wstrb_reg[0]) begin
          case (awaddr_reg)
            // latch always stored; drive depends on direction
            `GPIO_OFS_DATA: begin
              data_latch_reg <= wdata_reg[WIDTH-1:0];
            end
            `GPIO_OFS_DIR: begin
              direction_reg <= wdata_reg[WIDTH-1:0];
            end
            `GPIO_OFS_PULL: begin
              pullup_reg <= wdata_reg[WIDTH-1:0];
            end
            `GPIO_OFS_STBY: begin
              standby_control_reg <= wdata_reg[3:0];
            end
            default: begin
              s_axi_bresp <= `GPIO_RESP_SLVERR;
            end
          endcase
        end else if (awaddr_reg != `GPIO_OFS_DATA && awaddr_reg != `GPIO_OFS_DIR &&
                     awaddr_reg != `GPIO_OFS_PULL && awaddr_reg != `GPIO_OFS_STBY) begin
          s_axi_bresp <= `GPIO_RESP_SLVERR;
        end
      end
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  reg [31:0] rd_next;
  reg [1:0] rresp_next;
  wire [WIDTH-1:0] data_read;
  wire latch_rd;

  assign latch_rd = standby_control_reg[`GPIO_STBY_LATCH_RD_BIT];
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_rd
      // input pin reads pin unless read_modify_write_access
      // pin level regardless of peripheral use
      assign data_read[gi] = (direction_reg[gi] | latch_rd) ? data_latch_reg[gi] :
        periph_in[gi];
    end
  endgenerate

  always @* begin
    rd_next = 32'h0000_0000;
    rresp_next = `GPIO_RESP_OKAY;
    case (s_axi_araddr)
      `GPIO_OFS_DATA: begin
        rd_next[WIDTH-1:0] = data_read;
      end
      `GPIO_OFS_DIR: begin
        rd_next[WIDTH-1:0] = direction_reg;
      end
      `GPIO_OFS_PULL: begin
        rd_next[WIDTH-1:0] = pullup_reg;
      end
      `GPIO_OFS_STBY: begin
        rd_next[3:0] = standby_control_reg;
      end
      default: begin
        rresp_next = `GPIO_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `GPIO_RESP_OKAY;
    end else if (ce) begin
      // accept one read at a time; hold arready low while data waits
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_next;
        s_axi_rresp <= rresp_next;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  reg [WIDTH-1:0] oe_next;
  reg [WIDTH-1:0] pull_next;
  reg [WIDTH-1:0] pin_in_next;
  integer k;

  always @* begin
    oe_next = {WIDTH{1'b0}};
    pull_next = {WIDTH{1'b0}};
    pin_in_next = {WIDTH{1'b0}};
    for (k = 0; k < WIDTH; k = k + 1) begin
      if (standby_hiz) begin
        oe_next[k] = 1'b0;
        pin_in_next[k] = 1'b0;
        pull_next[k] = 1'b0;
      end else begin
        // zero is input; one drives latch
        // without hiz select standby changes nothing
        oe_next[k] = direction_reg[k];
        pin_in_next[k] = pin_sync[k];
        // pull-up on; off while driving low
        pull_next[k] = pullup_reg[k] & ~(direction_reg[k] & ~data_latch_reg[k]);
      end
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_out <= {WIDTH{1'b0}};
      pin_oe <= {WIDTH{1'b0}};
      pin_pullup_en <= {WIDTH{1'b0}};
      periph_in <= {WIDTH{1'b0}};
    end else if (ce) begin
      pin_out <= data_latch_reg;
      pin_oe <= oe_next;
      pin_pullup_en <= pull_next;
      periph_in <= pin_in_next;
    end
  end

endmodule // gpio_port
`default_nettype wire

// >>> sim/gpio_monitor.sv
/* port checker for gpio_port.
   assumes sys_clk, async active-high rst, bound below. */
`timescale 1ns/10ps
`default_nettype none
module gpio_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  input wire logic [7:0] periph_in
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ---
  // checks
  // ---
  a_reset_all_in: assert property (disable iff (1'b0) rst |-> pin_oe == 8'h00)
    else $error("pins driven in reset");
  a_pull_off_low: assert property (!(|(pin_pullup_en & pin_oe & ~pin_out)))
    else $error("pull-up on low output");
  a_periph_follow: assert property (
    $stable(pin_in) [*8] ##0 periph_in != 8'h00 |-> periph_in == pin_in)
    else $error("periph_in not pin level");
  a_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
    else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_pull: cover property (pin_pullup_en != 8'h00);
endmodule // gpio_monitor
bind gpio_port gpio_monitor mon_u (.*);
`default_nettype wire

// >>> sim/gpio_pad_model.sv
/* pad and board model for gpio_port pins.
   assumes ext_en high means the board drives ext_val. */
`timescale 1ns/10ps
`default_nettype none
module gpio_pad_model (
  input wire logic sys_clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  logic [7:0] last_reg;
  always @(posedge sys_clk) last_reg <= pin_in;
  // drive, board, pull-up; floating pins wander
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val)
    | (~ext_en & (pin_pullup_en | ~last_reg))));
endmodule // gpio_pad_model
`default_nettype wire

// >>> sim/general_purpose_io_port_tb_top.sv
/* self-checking bench for gpio_port over axi4-lite.
   assumes gpio_pad_model on the pins, ce held high. */
`timescale 1ns/10ps
`default_nettype none
`include "gpio_defs.vh"
module general_purpose_io_port_tb_top;
  logic sys_clk = 0, rst = 0, ce = 1;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] ext_val = 0, ext_en = 8'hff;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] pin_in, pin_out, pin_oe, pin_pullup_en, periph_in;
  int fails = 0, checked = 0;
  gpio_port dut_u (.*);
  gpio_pad_model pad_u (.*);
  always #50 sys_clk = ~sys_clk;
  // ---
  // helpers
  // ---
  task report_and_stop;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task ck(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task tmo;
    fails++;
    $display("[FAIL] %0t bus wait ran out", $time);
    report_and_stop;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic pa, pw;
    pa = 1;
    pw = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 80 && (pa || pw); n++) begin
      @(posedge sys_clk);
      if (pa && s_axi_awready === 1) begin pa = 0; s_axi_awvalid <= 0; end
      if (pw && s_axi_wready === 1) begin pw = 0; s_axi_wvalid <= 0; end
    end
    for (; n < 80; n++) begin
      @(posedge sys_clk);
      if (s_axi_bvalid === 1) break;
    end
    if (n >= 80) tmo;
    ck(s_axi_bresp, r);
    s_axi_bready <= 0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (s_axi_arready === 1) break;
    end
    s_axi_arvalid <= 0;
    for (; n < 80; n++) begin
      @(posedge sys_clk);
      if (s_axi_rvalid === 1) break;
    end
    if (n >= 80) tmo;
    ck(s_axi_rdata, e);
    ck(s_axi_rresp, r);
    s_axi_rready <= 0;
    @(posedge sys_clk);
  endtask
  // ---
  // scenarios
  // ---
  task t_reset;
    rd(`GPIO_OFS_DIR, 0, `GPIO_RESP_OKAY);
    ck(pin_oe, 8'h00);
  endtask
  task t_mixed;
    ext_val <= 8'h5a;
    wr(`GPIO_OFS_DIR, 32'h0f, `GPIO_RESP_OKAY);
    wr(`GPIO_OFS_DATA, 32'ha5, `GPIO_RESP_OKAY);
    ck(pin_oe, 8'h0f);
    ck(pin_out, 8'ha5);
    repeat (8) @(posedge sys_clk);
    rd(`GPIO_OFS_DATA, 32'h55, `GPIO_RESP_OKAY);
    ck(periph_in, 8'h55);
    wr(`GPIO_OFS_STBY, 32'h8, `GPIO_RESP_OKAY);
    rd(`GPIO_OFS_DATA, 32'ha5, `GPIO_RESP_OKAY);
    wr(`GPIO_OFS_STBY, 32'h0, `GPIO_RESP_OKAY);
  endtask
  task t_pull;
    ext_en <= 8'h00;
    wr(`GPIO_OFS_PULL, 32'hff, `GPIO_RESP_OKAY);
    wr(`GPIO_OFS_DATA, 32'h05, `GPIO_RESP_OKAY);
    ck(pin_pullup_en, 8'hf5);
    ext_en <= 8'hff;
  endtask
  task t_standby;
    logic [3:0] s [4] = '{4'h3, 4'h5, 4'h2, 4'h4};
    logic f;
    int i;
    ext_val <= 8'ha5;
    wr(`GPIO_OFS_DIR, 32'hff, `GPIO_RESP_OKAY);
    wr(`GPIO_OFS_DATA, 32'ha5, `GPIO_RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      f = s[i][0] & (s[i][1] | s[i][2]);
      wr(`GPIO_OFS_STBY, {28'h0, s[i]}, `GPIO_RESP_OKAY);
      repeat (8) @(posedge sys_clk);
      ck(pin_oe, f ? 8'h00 : 8'hff);
      ck(periph_in, f ? 8'h00 : 8'ha5);
      ck(pin_pullup_en, f ? 8'h00 : 8'ha5);
      ck(pin_out, 8'ha5);
    end
    wr(`GPIO_OFS_STBY, 32'h0, `GPIO_RESP_OKAY);
  endtask
  task t_unmapped;
    wr(4'h6, 32'hff, `GPIO_RESP_SLVERR);
    rd(4'h6, 32'h0, `GPIO_RESP_SLVERR);
  endtask
  initial begin
    // an edge on rst is needed, an initialiser alone leaves the design unknown
    rst <= 1;
    repeat (10) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    t_reset;
    // board drives input pins, no shared output active
    t_mixed;
    t_pull;
    t_standby;
    t_unmapped;
    report_and_stop;
  end
endmodule // general_purpose_io_port_tb_top
`default_nettype wire
